// ### rtl/stcr_top.v
// Self-test, I2C timing and audio path register bank with serial slave port
// Overview of operation
// - Bit 3 picks self-test enable source: 0 register, 1 pin; pin at reset.
// - Bits 2:1 choose oscillator; 00 and 01 both mean 33 MHz; reset 00.
// - Oscillator runs functional mode when pixel clock absent and 0x03[1]=1.
// - Low-frequency select makes the oscillator 12.5 MHz instead of 33 MHz.
// - Control bit 0 enables self test when one; reset value zero.
// - Self-test forward-channel errors go to a saturating 8-bit counter.
// - Error count clears when power-down pin low or new self test starts.
// - High-time register sets master clock high width; reset 0x83.
// - Low-time register sets master clock low width; reset 0x84.
// - Both widths count in 50 ns units of the nominal oscillator.
// - As slave, low-time value is data setup before clock line release.
// - Bit 7 of audio control blocks forward-channel loads of that register.
// - Bit 3 puts auxiliary audio on general pins: pin 1 select, pin 0 data.
// - Bit 2 disables the audio serial data outputs, not aux audio on general pins; clear at reset.
// - Bit 0 selects surround audio; else 2 or 4 channels by mode pin.
// - Surround audio only with data-island transport, never frame transport.
// - In repeater mode in-band detected audio mode overrides surround bit.
// - Low-frequency select marks clock range below 15 MHz versus 15 to 85.
`include "stcr_regs.vh"
`default_nettype none

module stcr_top #(
   parameter [6:0] DEV_ADDR = 7'h2c,
   parameter       CNT_W    = 12
) (
   // Clock and reset
   input  wire       CLK,
   input  wire       SYS_RST,
   // Serial control bus pins
   input  wire       SCL_IN,
   output reg        SCL_OUT,
   output reg        SCL_OE_N,
   input  wire       SDA_IN,
   output reg        SDA_OUT,
   output reg        SDA_OE_N,
   // Device pins sampled from outside the clock domain
   input  wire       SELF_TEST_PIN,
   input  wire       POWER_DOWN_PIN_N,
   input  wire       LOW_FREQ_SELECT,
   // Core status inputs
   input  wire       PCLK_PRESENT,
   input  wire       OSC_FUNC_ENABLE,
   input  wire       FC_ERROR,
   input  wire       MASTER_ACTIVE,
   input  wire       FWD_LOAD,
   input  wire [7:0] FWD_DATA,
   // Audio and general pins
   input  wire [1:0] GPIO_IN,
   input  wire       AUX_WS,
   input  wire       AUX_DATA,
   input  wire [3:0] AUDIO_SD_IN,
   input  wire       REPEATER,
   input  wire       INBAND_VALID,
   input  wire       INBAND_SURROUND,
   input  wire       MODE_SEL_FOUR,
   input  wire       FRAME_TRANSPORT,
   // Self-test and oscillator outputs
   output reg        SELF_TEST_ACTIVE,
   output reg  [1:0] OSC_SOURCE,
   output reg        USE_INT_OSC,
   output reg        OSC_LOW_FREQ,
   // Local bus master clock
   output reg        MASTER_SCL_OE_N,
   // Audio path outputs
   output reg        AUX_AUDIO_EN,
   output reg  [1:0] GPIO_OUT,
   output reg        AUDIO_DISABLE,
   output reg  [3:0] AUDIO_SD_OUT,
   output reg        SURROUND_ACTIVE,
   output reg        FOUR_CHANNEL
);

   localparam integer UNIT_NOM_I =
      (`STCR_UNIT_NS + `STCR_CLK_NS - 1) / `STCR_CLK_NS;
   localparam integer UNIT_LF_NS =
      `STCR_UNIT_NS * `STCR_OSC_NOM_KHZ / `STCR_OSC_LF_KHZ;
   localparam integer UNIT_LF_I =
      (UNIT_LF_NS + `STCR_CLK_NS - 1) / `STCR_CLK_NS;
   localparam [CNT_W-1:0] UNIT_CYC_NOM = UNIT_NOM_I[CNT_W-1:0];
   localparam [CNT_W-1:0] UNIT_CYC_LF  = UNIT_LF_I[CNT_W-1:0];
   localparam [7:0]       CTRL_RST     = `STCR_RST_ST_CTRL;

   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_ADDR = 4'h1;
   localparam [3:0] ST_AACK = 4'h2;
   localparam [3:0] ST_PTR  = 4'h3;
   localparam [3:0] ST_PACK = 4'h4;
   localparam [3:0] ST_WR   = 4'h5;
   localparam [3:0] ST_RD   = 4'h6;
   localparam [3:0] ST_RACK = 4'h7;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, change taken when stages 2 and 3 agree

   localparam NSYNC = 5;
   // Every stage idles at its pin's rest level, so no false edge after reset
   localparam [NSYNC-1:0] SYNC_RST = `STCR_SYNC_RST;
   wire [NSYNC-1:0] pin_raw = {LOW_FREQ_SELECT, POWER_DOWN_PIN_N,
                               SELF_TEST_PIN, SDA_IN, SCL_IN};
   reg  [NSYNC-1:0] sync1_r;
   reg  [NSYNC-1:0] sync2_r;
   reg  [NSYNC-1:0] sync3_r;
   reg  [NSYNC-1:0] filt_r;
   reg  [NSYNC-1:0] filt_prev_r;

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
         always @(posedge CLK) begin
            if (SYS_RST) begin
               sync1_r[gi] <= SYNC_RST[gi];
               sync2_r[gi] <= SYNC_RST[gi];
               sync3_r[gi] <= SYNC_RST[gi];
               filt_r[gi]  <= SYNC_RST[gi];
            end else begin
               sync1_r[gi] <= pin_raw[gi];
               sync2_r[gi] <= sync1_r[gi];
               sync3_r[gi] <= sync2_r[gi];
               if (sync2_r[gi] == sync3_r[gi]) begin
                  filt_r[gi] <= sync3_r[gi];
               end
            end
         end
      end
   endgenerate

   always @(posedge CLK) begin
      if (SYS_RST) begin
         filt_prev_r <= SYNC_RST;
      end else begin
         filt_prev_r <= filt_r;
      end
   end

   wire scl_f    = filt_r[0];
   wire sda_f    = filt_r[1];
   wire st_pin_f = filt_r[2];
   wire pdn_n_f  = filt_r[3];
   wire lf_f     = filt_r[4];
   wire scl_rise = scl_f & ~filt_prev_r[0];
   wire scl_fall = ~scl_f & filt_prev_r[0];
   wire bus_start = scl_f & filt_prev_r[0] & filt_prev_r[1] & ~sda_f;
   wire bus_stop  = scl_f & filt_prev_r[0] & ~filt_prev_r[1] & sda_f;

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   reg        st_pin_cfg_r;
   reg  [1:0] st_osc_r;
   reg        st_en_r;
   reg  [7:0] err_cnt_r;
   reg  [7:0] scl_high_r;
   reg  [7:0] scl_low_r;
   reg  [7:0] ap_ctrl_r;
   reg        st_act_prev_r;

   reg  [3:0] state_r;
   reg  [3:0] bitcnt_r;
   reg  [7:0] shreg_r;
   reg  [7:0] txsh_r;
   reg  [7:0] ptr_r;
   reg        nack_r;
   reg        host_wr;
   reg  [7:0] rd_data;

   wire st_active = st_pin_cfg_r ? st_pin_f : st_en_r;
   wire st_start  = st_active & ~st_act_prev_r;

   always @* begin
      case (ptr_r)
         `STCR_ADDR_ST_CTRL:
            rd_data = {{`STCR_ST_RSVD_W{1'b0}}, st_pin_cfg_r,
                       st_osc_r, st_en_r};
         `STCR_ADDR_ST_ERRCNT:   rd_data = err_cnt_r;
         `STCR_ADDR_SCL_HIGH:    rd_data = scl_high_r;
         `STCR_ADDR_SCL_LOW:     rd_data = scl_low_r;
         `STCR_ADDR_AUDIO_CTRL2:
            rd_data = ap_ctrl_r & `STCR_AP_WMASK;
         default:                rd_data = 8'h00;
      endcase
   end

   wire wr_now = host_wr;

   always @(posedge CLK) begin
      if (SYS_RST) begin
         st_pin_cfg_r  <= CTRL_RST[`STCR_ST_PIN_CFG_BIT];
         st_osc_r      <= CTRL_RST[`STCR_ST_OSC_HI:`STCR_ST_OSC_LO];
         st_en_r       <= CTRL_RST[`STCR_ST_EN_BIT];
         scl_high_r    <= `STCR_RST_SCL_HIGH;
         scl_low_r     <= `STCR_RST_SCL_LOW;
         ap_ctrl_r     <= `STCR_RST_AUDIO_CTRL2;
         err_cnt_r     <= `STCR_RST_ST_ERRCNT;
         st_act_prev_r <= 1'b0;
      end else begin
         st_act_prev_r <= st_active;
         if (wr_now && ptr_r == `STCR_ADDR_ST_CTRL) begin
            st_pin_cfg_r <= shreg_r[`STCR_ST_PIN_CFG_BIT];
            st_osc_r     <= shreg_r[`STCR_ST_OSC_HI:`STCR_ST_OSC_LO];
            st_en_r      <= shreg_r[`STCR_ST_EN_BIT];
         end
         if (wr_now && ptr_r == `STCR_ADDR_SCL_HIGH) begin
            scl_high_r <= shreg_r;
         end
         if (wr_now && ptr_r == `STCR_ADDR_SCL_LOW) begin
            scl_low_r <= shreg_r;
         end
         if (wr_now && ptr_r == `STCR_ADDR_AUDIO_CTRL2) begin
            ap_ctrl_r <= shreg_r & `STCR_AP_WMASK;
         end else if (FWD_LOAD &&
                      !ap_ctrl_r[`STCR_AP_BLOCK_FWD_BIT]) begin
            ap_ctrl_r <= (FWD_DATA & `STCR_AP_WMASK) |
                         (ap_ctrl_r & (8'h01 << `STCR_AP_BLOCK_FWD_BIT));
         end
         if (!pdn_n_f || st_start) begin
            err_cnt_r <= `STCR_RST_ST_ERRCNT;
         end else if (st_active && FC_ERROR &&
                      err_cnt_r != `STCR_ERR_MAX) begin
            err_cnt_r <= err_cnt_r + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial control bus slave

   wire addressed = (state_r != ST_IDLE) && (state_r != ST_ADDR);

   always @(posedge CLK) begin
      if (SYS_RST) begin
         state_r  <= ST_IDLE;
         bitcnt_r <= 4'h0;
         shreg_r  <= 8'h00;
         txsh_r   <= 8'h00;
         ptr_r    <= 8'h00;
         nack_r   <= 1'b0;
         host_wr  <= 1'b0;
         SDA_OUT  <= 1'b0;
         SDA_OE_N <= 1'b1;
      end else begin
         host_wr <= 1'b0;
         if (bus_start) begin
            state_r  <= ST_ADDR;
            bitcnt_r <= 4'h0;
            SDA_OE_N <= 1'b1;
         end else if (bus_stop) begin
            state_r  <= ST_IDLE;
            SDA_OE_N <= 1'b1;
         end else if (scl_rise) begin
            if (state_r == ST_RACK) begin
               nack_r <= sda_f;
            end else if (state_r == ST_ADDR || state_r == ST_PTR ||
                         state_r == ST_WR || state_r == ST_RD) begin
               shreg_r  <= {shreg_r[6:0], sda_f};
               bitcnt_r <= bitcnt_r + 4'h1;
            end
         end else if (scl_fall) begin
            case (state_r)
               ST_ADDR: begin
                  if (bitcnt_r == 4'h8) begin
                     bitcnt_r <= 4'h0;
                     if (shreg_r[7:1] == DEV_ADDR) begin
                        nack_r   <= shreg_r[0];
                        SDA_OE_N <= 1'b0;
                        state_r  <= ST_AACK;
                     end else begin
                        state_r <= ST_IDLE;
                     end
                  end
               end
               ST_AACK: begin
                  bitcnt_r <= 4'h0;
                  if (nack_r) begin
                     txsh_r   <= {rd_data[6:0], 1'b0};
                     SDA_OE_N <= rd_data[7];
                     state_r  <= ST_RD;
                  end else begin
                     SDA_OE_N <= 1'b1;
                     state_r  <= ST_PTR;
                  end
               end
               ST_PTR, ST_WR: begin
                  if (bitcnt_r == 4'h8) begin
                     bitcnt_r <= 4'h0;
                     SDA_OE_N <= 1'b0;
                     state_r  <= ST_PACK;
                     if (state_r == ST_PTR) begin
                        ptr_r <= shreg_r;
                     end else begin
                        host_wr <= 1'b1;
                     end
                  end
               end
               ST_PACK: begin
                  if (host_wr == 1'b0 && state_r == ST_PACK) begin
                     SDA_OE_N <= 1'b1;
                     state_r  <= ST_WR;
                  end
               end
               ST_RD: begin
                  if (bitcnt_r == 4'h8) begin
                     SDA_OE_N <= 1'b1;
                     ptr_r    <= ptr_r + 8'h01;
                     state_r  <= ST_RACK;
                  end else begin
                     SDA_OE_N <= txsh_r[7];
                     txsh_r   <= {txsh_r[6:0], 1'b0};
                  end
               end
               ST_RACK: begin
                  bitcnt_r <= 4'h0;
                  if (nack_r) begin
                     state_r <= ST_IDLE;
                  end else begin
                     txsh_r   <= {rd_data[6:0], 1'b0};
                     SDA_OE_N <= rd_data[7];
                     state_r  <= ST_RD;
                  end
               end
               default: state_r <= ST_IDLE;
            endcase
         end else if (host_wr) begin
            ptr_r <= ptr_r + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pulse-width unit, slave clock stretch and master clock generator

   wire [CNT_W-1:0] unit_cyc = lf_f ? UNIT_CYC_LF : UNIT_CYC_NOM;
   wire [CNT_W-1:0] low_cyc  = {{(CNT_W-8){1'b0}}, scl_low_r} * unit_cyc;
   wire [CNT_W-1:0] high_cyc = {{(CNT_W-8){1'b0}}, scl_high_r} * unit_cyc;

   reg  [CNT_W-1:0] stretch_r;
   reg  [CNT_W-1:0] mclk_cnt_r;
   reg              mclk_high_r;

   always @(posedge CLK) begin
      if (SYS_RST) begin
         stretch_r <= {CNT_W{1'b0}};
         SCL_OUT   <= 1'b0;
         SCL_OE_N  <= 1'b1;
      end else if (scl_fall && addressed && low_cyc != {CNT_W{1'b0}}) begin
         stretch_r <= low_cyc;
         SCL_OE_N  <= 1'b0;
      end else if (stretch_r != {CNT_W{1'b0}}) begin
         stretch_r <= stretch_r - {{(CNT_W-1){1'b0}}, 1'b1};
         SCL_OE_N  <= (stretch_r == {{(CNT_W-1){1'b0}}, 1'b1});
      end else begin
         SCL_OE_N <= 1'b1;
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         mclk_cnt_r      <= {CNT_W{1'b0}};
         mclk_high_r     <= 1'b1;
         MASTER_SCL_OE_N <= 1'b1;
      end else if (!MASTER_ACTIVE) begin
         mclk_cnt_r      <= {CNT_W{1'b0}};
         mclk_high_r     <= 1'b1;
         MASTER_SCL_OE_N <= 1'b1;
      end else if (mclk_cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
         mclk_high_r     <= ~mclk_high_r;
         MASTER_SCL_OE_N <= ~mclk_high_r;
         mclk_cnt_r <= mclk_high_r ? low_cyc : high_cyc;
      end else begin
         mclk_cnt_r <= mclk_cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output flops

   wire surround_req = (REPEATER && INBAND_VALID) ? INBAND_SURROUND
                       : ap_ctrl_r[`STCR_AP_SURROUND_BIT];
   wire surround_ok  = surround_req & ~FRAME_TRANSPORT;
   wire aux_en       = ap_ctrl_r[`STCR_AP_AUX_BIT];
   wire aud_dis      = ap_ctrl_r[`STCR_AP_DISABLE_BIT];

   always @(posedge CLK) begin
      if (SYS_RST) begin
         SELF_TEST_ACTIVE <= 1'b0;
         OSC_SOURCE       <= 2'h0;
         USE_INT_OSC      <= 1'b0;
         OSC_LOW_FREQ     <= 1'b0;
         AUX_AUDIO_EN     <= 1'b0;
         GPIO_OUT         <= 2'h0;
         AUDIO_DISABLE    <= 1'b0;
         AUDIO_SD_OUT     <= 4'h0;
         SURROUND_ACTIVE  <= 1'b0;
         FOUR_CHANNEL     <= 1'b0;
      end else begin
         SELF_TEST_ACTIVE <= st_active;
         OSC_SOURCE       <= st_osc_r;
         USE_INT_OSC      <= st_active |
                             (~PCLK_PRESENT & OSC_FUNC_ENABLE);
         OSC_LOW_FREQ     <= lf_f;
         AUX_AUDIO_EN     <= aux_en;
         GPIO_OUT         <= aux_en ? {AUX_WS, AUX_DATA} : GPIO_IN;
         AUDIO_DISABLE    <= aud_dis;
         AUDIO_SD_OUT     <= aud_dis ? 4'h0 : AUDIO_SD_IN;
         SURROUND_ACTIVE  <= surround_ok;
         FOUR_CHANNEL     <= ~surround_ok & MODE_SEL_FOUR;
      end
   end

endmodule

`default_nettype wire

// ### rtl/stcr_regs.vh
// Register map, field positions, reset values and timing for the test bank
`ifndef STCR_REGS_VH
`define STCR_REGS_VH

// Register offsets
`define STCR_ADDR_ST_CTRL     8'h24
`define STCR_ADDR_ST_ERRCNT   8'h25
`define STCR_ADDR_SCL_HIGH    8'h26
`define STCR_ADDR_SCL_LOW     8'h27
`define STCR_ADDR_AUDIO_CTRL2 8'h28

// Reset values
`define STCR_RST_ST_CTRL      8'h08
`define STCR_RST_ST_ERRCNT    8'h00
`define STCR_RST_SCL_HIGH     8'h83
`define STCR_RST_SCL_LOW      8'h84
`define STCR_RST_AUDIO_CTRL2  8'h00
// Synchroniser idle levels: LF, power-down, self-test pin, SDA, SCL
`define STCR_SYNC_RST         5'h0b

// Self-test control fields
`define STCR_ST_PIN_CFG_BIT   3
`define STCR_ST_OSC_HI        2
`define STCR_ST_OSC_LO        1
`define STCR_ST_EN_BIT        0
`define STCR_ST_RSVD_W        4

// Audio path control fields
`define STCR_AP_BLOCK_FWD_BIT 7
`define STCR_AP_AUX_BIT       3
`define STCR_AP_DISABLE_BIT   2
`define STCR_AP_SURROUND_BIT  0
`define STCR_AP_WMASK         8'h8d

// Error counter ceiling
`define STCR_ERR_MAX          8'hff

// Timing: clock period, pulse-width unit, oscillator rates
`define STCR_CLK_NS           40
`define STCR_UNIT_NS          50
`define STCR_OSC_NOM_KHZ      33000
`define STCR_OSC_LF_KHZ       12500

`endif

// ### dv/stcr_asserts.sv
// Port-level property checker for the self-test and audio register bank
`default_nettype none
module stcr_asserts (
   // Clock and reset
   input wire logic       CLK,
   input wire logic       SYS_RST,
   // Observed inputs
   input wire logic       LOW_FREQ_SELECT,
   input wire logic       PCLK_PRESENT,
   input wire logic       OSC_FUNC_ENABLE,
   input wire logic       MASTER_ACTIVE,
   input wire logic [1:0] GPIO_IN,
   input wire logic       AUX_WS,
   input wire logic       AUX_DATA,
   input wire logic [3:0] AUDIO_SD_IN,
   input wire logic       REPEATER,
   input wire logic       INBAND_VALID,
   input wire logic       INBAND_SURROUND,
   input wire logic       FRAME_TRANSPORT,
   // Observed outputs
   input wire logic       SDA_OE_N,
   input wire logic       SELF_TEST_ACTIVE,
   input wire logic       USE_INT_OSC,
   input wire logic       OSC_LOW_FREQ,
   input wire logic       MASTER_SCL_OE_N,
   input wire logic       AUX_AUDIO_EN,
   input wire logic [1:0] GPIO_OUT,
   input wire logic       AUDIO_DISABLE,
   input wire logic [3:0] AUDIO_SD_OUT,
   input wire logic       SURROUND_ACTIVE,
   input wire logic       FOUR_CHANNEL
);
   timeunit 1ns;
   timeprecision 100ps;
   logic rst_q_r;
   // Masks the first edge after reset, where past values are stale
   always @(posedge CLK) begin
      rst_q_r <= SYS_RST;
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST || rst_q_r);
   AST_AUDIO_MUTE: assert property (AUDIO_DISABLE && $past(AUDIO_DISABLE) |->
      AUDIO_SD_OUT == 4'h0) else $error("audio not muted");
   AST_AUDIO_PASS: assert property (!AUDIO_DISABLE && !$past(AUDIO_DISABLE)
      |-> AUDIO_SD_OUT == $past(AUDIO_SD_IN)) else $error("audio not passed");
   AST_AUX_PINS: assert property (AUX_AUDIO_EN && $past(AUX_AUDIO_EN) |->
      GPIO_OUT == $past({AUX_WS, AUX_DATA})) else $error("aux pins wrong");
   AST_GPIO_PASS: assert property (!AUX_AUDIO_EN && !$past(AUX_AUDIO_EN)
      |-> GPIO_OUT == $past(GPIO_IN)) else $error("general pins wrong");
   AST_FOUR_CH: assert property (FOUR_CHANNEL |-> !SURROUND_ACTIVE)
      else $error("four channel with surround");
   AST_FRAME_NO_SURR: assert property ($past(FRAME_TRANSPORT) |->
      !SURROUND_ACTIVE) else $error("surround on frame transport");
   AST_INBAND_OVR: assert property ($past(REPEATER && INBAND_VALID &&
      !FRAME_TRANSPORT) |-> SURROUND_ACTIVE == $past(INBAND_SURROUND))
      else $error("in-band mode not applied");
   AST_INT_OSC: assert property ($past(!PCLK_PRESENT && OSC_FUNC_ENABLE)
      |-> USE_INT_OSC) else $error("internal oscillator not used");
   AST_LOW_FREQ: assert property (LOW_FREQ_SELECT [*8] |-> OSC_LOW_FREQ)
      else $error("low frequency not followed");
   AST_MCLK_START: assert property ($rose(MASTER_ACTIVE) |=>
      !MASTER_SCL_OE_N) else $error("master clock low phase late");
   AST_MCLK_IDLE: assert property (!MASTER_ACTIVE && !$past(MASTER_ACTIVE)
      |-> MASTER_SCL_OE_N) else $error("master clock driven when idle");
   cover property ($rose(SELF_TEST_ACTIVE));
   cover property (!SDA_OE_N);
   cover property (SURROUND_ACTIVE && !FOUR_CHANNEL);
endmodule

bind stcr_top stcr_asserts u_chk (.CLK, .SYS_RST, .LOW_FREQ_SELECT,
   .PCLK_PRESENT, .OSC_FUNC_ENABLE, .MASTER_ACTIVE, .GPIO_IN, .AUX_WS,
   .AUX_DATA, .AUDIO_SD_IN, .REPEATER, .INBAND_VALID, .INBAND_SURROUND,
   .FRAME_TRANSPORT, .SDA_OE_N, .SELF_TEST_ACTIVE, .USE_INT_OSC,
   .OSC_LOW_FREQ, .MASTER_SCL_OE_N, .AUX_AUDIO_EN, .GPIO_OUT,
   .AUDIO_DISABLE, .AUDIO_SD_OUT, .SURROUND_ACTIVE, .FOUR_CHANNEL);
`default_nettype wire

// ### dv/stcr_host.sv
// Serial control bus master model, the host side of the register bank
`default_nettype none
module stcr_host (
   // Clock
   input  wire logic CLK,
   // Wired bus levels
   input  wire logic scl_w,
   input  wire logic sda_w,
   // Pin pulls, 1 releases the wire
   output var  logic scl_d,
   output var  logic sda_d
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] rb [0:7];
   logic [7:0] dq;
   logic       ak;
   initial begin
      scl_d = 1'b1;
      sda_d = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   // Release the clock and wait out the device's stretch
   task automatic rise;
      int k;
      scl_d = 1'b1;
      k = 0;
      while (scl_w !== 1'b1 && k < 4000) begin
         tick(1);
         k++;
      end
      tick(8);
   endtask
   task automatic bitx(input logic b, output logic r);
      sda_d = b;
      tick(8);
      rise;
      r = sda_w;
      scl_d = 1'b0;
      tick(2);
   endtask
   task automatic xfer(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--)
         bitx(d[i], q[i]);
      bitx(a, ack);
   endtask
   task automatic start;
      sda_d = 1'b1;
      tick(8);
      rise;
      sda_d = 1'b0;
      tick(8);
      scl_d = 1'b0;
      tick(8);
   endtask
   task automatic stop;
      sda_d = 1'b0;
      tick(8);
      rise;
      sda_d = 1'b1;
      tick(8);
   endtask
   // Device address 0x2c, write then read direction bytes
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      start;
      xfer(8'h58, 1'b1, dq, ak);
      xfer(p, 1'b1, dq, ak);
      xfer(d, 1'b1, dq, ak);
      stop;
   endtask
   task automatic rd(input logic [7:0] p, input int n);
      start;
      xfer(8'h58, 1'b1, dq, ak);
      xfer(p, 1'b1, dq, ak);
      start;
      xfer(8'h59, 1'b1, dq, ak);
      for (int i = 0; i < n; i++)
         xfer(8'hff, (i == n - 1), rb[i], ak);
      stop;
   endtask
endmodule
`default_nettype wire

// ### dv/stcr_top_test.sv
// Self-checking bench for the self-test, bus timing and audio register bank
`include "stcr_regs.vh"
`default_nettype none
module stcr_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int UNIT = (`STCR_UNIT_NS + `STCR_CLK_NS - 1) / `STCR_CLK_NS;
   localparam logic [7:0] HI_W = 8'(16 * UNIT);
   localparam logic [7:0] LO_W = 8'(4 * UNIT);
   localparam logic [7:0] RST [0:4] = '{`STCR_RST_ST_CTRL,
      `STCR_RST_ST_ERRCNT, `STCR_RST_SCL_HIGH, `STCR_RST_SCL_LOW,
      `STCR_RST_AUDIO_CTRL2};
   // Offset, written value, read-back value
   localparam logic [23:0] ROWS [0:6] = '{24'h270404, 24'h261010,
      24'h24f606, 24'h240202, 24'h28ff8d, 24'h25aa00, 24'h305500};
   logic       CLK, SYS_RST, SELF_TEST_PIN, POWER_DOWN_PIN_N;
   logic       LOW_FREQ_SELECT, PCLK_PRESENT, OSC_FUNC_ENABLE, FC_ERROR;
   logic       MASTER_ACTIVE, FWD_LOAD, AUX_WS, AUX_DATA, REPEATER;
   logic       INBAND_VALID, INBAND_SURROUND, MODE_SEL_FOUR, FRAME_TRANSPORT;
   logic [7:0] FWD_DATA;
   logic [1:0] GPIO_IN, OSC_SOURCE, GPIO_OUT;
   logic [3:0] AUDIO_SD_IN, AUDIO_SD_OUT;
   logic       SCL_OUT, SCL_OE_N, SDA_OUT, SDA_OE_N, SELF_TEST_ACTIVE;
   logic       USE_INT_OSC, OSC_LOW_FREQ, MASTER_SCL_OE_N, AUX_AUDIO_EN;
   logic       AUDIO_DISABLE, SURROUND_ACTIVE, FOUR_CHANNEL;
   logic       scl_d, sda_d, scl_w, sda_w;
   int         n_mismatch, cmp_count, i, n;
   // Open-drain wires with pull-ups
   assign scl_w = scl_d & (SCL_OE_N | SCL_OUT);
   assign sda_w = sda_d & (SDA_OE_N | SDA_OUT);
   stcr_top DUT (.CLK, .SYS_RST, .SCL_IN(scl_w), .SCL_OUT, .SCL_OE_N,
      .SDA_IN(sda_w), .SDA_OUT, .SDA_OE_N, .SELF_TEST_PIN, .POWER_DOWN_PIN_N,
      .LOW_FREQ_SELECT, .PCLK_PRESENT, .OSC_FUNC_ENABLE, .FC_ERROR,
      .MASTER_ACTIVE, .FWD_LOAD, .FWD_DATA, .GPIO_IN, .AUX_WS, .AUX_DATA,
      .AUDIO_SD_IN, .REPEATER, .INBAND_VALID, .INBAND_SURROUND,
      .MODE_SEL_FOUR, .FRAME_TRANSPORT, .SELF_TEST_ACTIVE, .OSC_SOURCE,
      .USE_INT_OSC, .OSC_LOW_FREQ, .MASTER_SCL_OE_N, .AUX_AUDIO_EN,
      .GPIO_OUT, .AUDIO_DISABLE, .AUDIO_SD_OUT, .SURROUND_ACTIVE,
      .FOUR_CHANNEL);
   stcr_host u_host (.CLK, .scl_w, .sda_w, .scl_d, .sda_d);
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   task automatic step(input int k);
      repeat (k) @(posedge CLK);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic fwd(input logic [7:0] d);
      FWD_DATA = d;
      FWD_LOAD = 1'b1;
      step(1);
      FWD_LOAD = 1'b0;
      step(3);
   endtask
   // Self test run: errors counted only while enabled
   task automatic st(input int k, input logic [7:0] exp);
      u_host.wr(8'h24, 8'h01);
      chk({SELF_TEST_ACTIVE, USE_INT_OSC}, 8'h03);
      repeat (k) begin
         FC_ERROR = 1'b1;
         step(1);
         FC_ERROR = 1'b0;
         step(1);
      end
      u_host.wr(8'h24, 8'h00);
      FC_ERROR = 1'b1;
      step(1);
      FC_ERROR = 1'b0;
      u_host.rd(8'h25, 1);
      chk(u_host.rb[0], exp);
   endtask
   // Longest clock stretch seen while one register write runs
   task automatic stretch_max(output int m);
      int c;
      m = 0;
      c = 0;
      fork
         u_host.wr(8'h26, 8'h10);
         repeat (3000) begin
            step(1);
            c = (SCL_OE_N === 1'b0) ? c + 1 : 0;
            if (c > m)
               m = c;
         end
      join
   endtask
   task automatic width(input logic v, output int c);
      c = 0;
      while (MASTER_SCL_OE_N === v && c < 600) begin
         step(1);
         c++;
      end
   endtask
   initial begin
      SYS_RST = 1'b1;
      POWER_DOWN_PIN_N = 1'b1;
      PCLK_PRESENT = 1'b1;
      {SELF_TEST_PIN, LOW_FREQ_SELECT, OSC_FUNC_ENABLE, FC_ERROR, FWD_LOAD,
       MASTER_ACTIVE, FWD_DATA, REPEATER, INBAND_VALID, INBAND_SURROUND,
       MODE_SEL_FOUR, FRAME_TRANSPORT} = '0;
      GPIO_IN = 2'h1;
      {AUX_WS, AUX_DATA} = 2'h2;
      AUDIO_SD_IN = 4'ha;
      step(12);
      SYS_RST = 1'b0;
      step(8);
      chk(SELF_TEST_ACTIVE, 8'h00);
      SELF_TEST_PIN = 1'b1;
      step(8);
      chk(SELF_TEST_ACTIVE, 8'h01);
      SELF_TEST_PIN = 1'b0;
      step(8);
      u_host.rd(8'h24, 5);
      for (i = 0; i < 5; i++)
         chk(u_host.rb[i], RST[i]);
      for (i = 0; i < 7; i++) begin
         u_host.wr(ROWS[i][23:16], ROWS[i][15:8]);
         u_host.rd(ROWS[i][23:16], 1);
         chk(u_host.rb[0], ROWS[i][7:0]);
      end
      stretch_max(n);
      chk(n[7:0], LO_W);
      chk(OSC_SOURCE, 8'h01);
      chk({AUX_AUDIO_EN, GPIO_OUT, AUDIO_DISABLE, AUDIO_SD_OUT}, 8'hd0);
      fwd(8'h00);
      chk({AUX_AUDIO_EN, AUDIO_DISABLE, SURROUND_ACTIVE}, 8'h07);
      u_host.wr(8'h28, 8'h00);
      fwd(8'h7d);
      chk({AUX_AUDIO_EN, AUDIO_DISABLE, SURROUND_ACTIVE}, 8'h07);
      MODE_SEL_FOUR = 1'b1;
      step(3);
      chk({SURROUND_ACTIVE, FOUR_CHANNEL}, 8'h02);
      FRAME_TRANSPORT = 1'b1;
      step(3);
      chk({SURROUND_ACTIVE, FOUR_CHANNEL}, 8'h01);
      FRAME_TRANSPORT = 1'b0;
      {REPEATER, INBAND_VALID} = 2'h3;
      step(3);
      chk({SURROUND_ACTIVE, FOUR_CHANNEL}, 8'h01);
      {REPEATER, INBAND_VALID} = 2'h0;
      fwd(8'h00);
      chk({AUX_AUDIO_EN, GPIO_OUT, AUDIO_DISABLE, AUDIO_SD_OUT}, 8'h2a);
      PCLK_PRESENT = 1'b0;
      OSC_FUNC_ENABLE = 1'b1;
      step(3);
      chk(USE_INT_OSC, 8'h01);
      PCLK_PRESENT = 1'b1;
      step(3);
      chk(USE_INT_OSC, 8'h00);
      LOW_FREQ_SELECT = 1'b1;
      step(10);
      chk(OSC_LOW_FREQ, 8'h01);
      LOW_FREQ_SELECT = 1'b0;
      step(10);
      st(3, 8'h03);
      st(2, 8'h02);
      st(300, 8'hff);
      POWER_DOWN_PIN_N = 1'b0;
      step(8);
      POWER_DOWN_PIN_N = 1'b1;
      step(8);
      u_host.rd(8'h25, 1);
      chk(u_host.rb[0], 8'h00);
      MASTER_ACTIVE = 1'b1;
      width(1'b1, n);
      width(1'b0, n);
      width(1'b1, n);
      chk(n[7:0], HI_W);
      width(1'b0, n);
      chk(n[7:0], LO_W);
      MASTER_ACTIVE = 1'b0;
      step(4);
      final_report;
   end
   initial begin
      repeat (95000) @(posedge CLK);
      n_mismatch++;
      final_report;
   end
endmodule
`default_nettype wire
